/* File: rtl/scm_params.svh */
// Offsets, field positions, reset values and counts for the selcall modem register bank
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

// Register offsets on the serial control bus
`define SCM_ADDR_GEN_RESET 8'h01
`define SCM_ADDR_MODEM_CFG 8'hc7
`define SCM_ADDR_PROG 8'hc8
`define SCM_ADDR_TX_PAIR 8'hca
`define SCM_ADDR_TONE_STAT 8'hcc
`define SCM_ADDR_TONE_SEL 8'hcd

// Modem configuration field positions
`define SCM_CFG_PAT_C 15
`define SCM_CFG_PAT_D 14
`define SCM_CFG_PAT_T 13
`define SCM_CFG_BYPASS 12
`define SCM_CFG_SELCALL 11
`define SCM_CFG_RAW 10
`define SCM_CFG_LAST 9
`define SCM_CFG_USER 2

// Transmit pair character flags
`define SCM_TX_FLAG0 15
`define SCM_TX_FLAG1 7

// Tone status fields
`define SCM_TS_IDX_HI 14
`define SCM_TS_IDX_LO 11
`define SCM_TS_VALID 10

// Audio tone word fields
`define SCM_AUD_SEL_HI 15
`define SCM_AUD_SEL_LO 12
`define SCM_AUD_VAL_HI 11

// Reset values
`define SCM_CFG_RST 16'h0000
`define SCM_LEVEL_RST 12'hfff
`define SCM_FREQ_RST 12'h000
`define SCM_MULT_RST 3'h0
`define SCM_FINE_RST 8'h00

// Serial frame bit counts
`define SCM_ADDR_LAST 5'd7
`define SCM_FRAME_LAST 5'd23
`define SCM_RD_TOP 5'd23

`endif

/* File: rtl/scm_pkg.sv */
// Types shared by the selcall modem register bank
package scm_pkg;

  typedef enum logic [1:0] {
    SCM_OP_IDLE = 2'b00,
    SCM_OP_RX = 2'b01,
    SCM_OP_TX = 2'b10,
    SCM_OP_RSVD = 2'b11
  } scm_opmode_t;

  typedef enum logic [1:0] {
    SCM_LNK_ADDR = 2'b00,
    SCM_LNK_DATA = 2'b01,
    SCM_LNK_DONE = 2'b10
  } scm_lnk_t;

  typedef enum logic [3:0] {
    SCM_SEL_FREQ = 4'h0,
    SCM_SEL_TONE_LVL = 4'h2,
    SCM_SEL_RX_VOICE = 4'h4,
    SCM_SEL_OUT1 = 4'h6,
    SCM_SEL_OUT2 = 4'h8,
    SCM_SEL_TX_MULT = 4'ha,
    SCM_SEL_FINE = 4'hc
  } scm_sel_t;

  typedef struct packed {
    logic frame_pattern_c_detect;
    logic frame_pattern_d_detect;
    logic frame_pattern_t_detect;
    logic weather_data_bypass;
    logic selcall_modem_select;
    logic raw_mode;
    logic last_block;
    logic user_bit;
  } scm_cfg_t;

  typedef struct packed {
    scm_opmode_t op_mode;
    logic modem_en;
    logic tone_gen_en;
  } scm_mode_t;

  typedef struct packed {
    logic [3:0] index;
    logic tone_valid;
  } scm_tone_det_t;

  typedef struct packed {
    logic [11:0] freq;
    logic [11:0] tone_level;
    logic [11:0] rx_voice;
    logic [11:0] out1_gain;
    logic [11:0] out2_gain;
    logic [2:0] tx_mult;
    logic [7:0] fine_atten;
  } scm_audio_t;

endpackage : scm_pkg

/* File: rtl/scm_regs.sv */
// Selcall modem, tone status and audio tone register bank behind the serial control bus
`timescale 1ns/1ps
`include "scm_params.svh"
// Operation
// - Three frame pattern detect enables at config bits 15, 14, 13.
// - Bypass bit set abandons weather sync search and outputs data at once.
// - Config bit 11 selects selcall modem; mode word enable starts and stops it.
// - Raw receive searches frame pattern, interrupts, delivers 16-bit receive words.
// - Raw transmit sends 16-bit words unchanged, no added sync or formatting.
// - Last-block marker honoured only in formatted selcall transmit, permits stop.
// - Spare user bit changes nothing in format, carried to receiver.
// - Transmit pair repeats the same two characters until new data arrives.
// - Word in progress completes before a newly loaded word starts.
// - Formatted mode skips the character whose flag bit is set.
// - Tone status shows identification code after power-on or general reset.
// - Tone status carries index in bits 14-11, valid bit 10.
// - Any change in the detected tone index or valid bit raises the tone event.
// - Tone status reads zero while in transmit mode.
// - Audio tone select bits 15-12 choose meaning of bits 11-0.
// - Select zero with tone enable plays frequency; zero value gives bias only.
// - Frequency writes apply during a tone once the serial write ends.
// - In transmit, data-ready raises whenever the next transmit word is needed.
module scm_regs
  import scm_pkg::*;
#(
  parameter logic [15:0] IDENT_CODE = 16'h0a5c // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_cmd_data,
  output logic link_reply_data,
  output logic link_reply_oe,
  input wire scm_mode_t mode_ctl,
  input wire scm_tone_det_t tone_det,
  input wire logic tx_word_take,
  output scm_cfg_t modem_cfg,
  output logic modem_run,
  output logic rx_raw_search,
  output logic [15:0] tx_word,
  output logic [1:0] tx_skip,
  output logic data_ready,
  output logic stop_permit,
  output logic [15:0] prog_word,
  output logic prog_strobe,
  output logic [15:0] tone_status,
  output logic tone_event,
  output scm_audio_t audio_cfg,
  output logic tone_on,
  output logic bias_only
);

  function automatic logic sel_known(input logic [3:0] sel);
    sel_known = (sel == SCM_SEL_FREQ) || (sel == SCM_SEL_TONE_LVL) || (sel == SCM_SEL_RX_VOICE) ||
                (sel == SCM_SEL_OUT1) || (sel == SCM_SEL_OUT2) || (sel == SCM_SEL_TX_MULT) ||
                (sel == SCM_SEL_FINE);
  endfunction : sel_known

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: serial shift, frame decode, reply
  logic lnk_rst;
  logic [4:0] cnt_r;
  logic [22:0] shift_r;
  logic [7:0] addr_r;
  scm_lnk_t phase_r;
  scm_lnk_t phase_nxt;
  logic [15:0] rd_sh_r;
  logic [7:0] hold_addr_r;
  logic [15:0] hold_data_r;
  logic wr_tog_r;
  logic reply_r;
  logic reply_oe_r;
  logic [15:0] shadow_r;

  assign lnk_rst = reset | link_cs_n;
  wire [7:0] addr_in = {shift_r[6:0], link_cmd_data};
  wire [15:0] data_in = {shift_r[14:0], link_cmd_data};
  wire addr_edge = (phase_r == SCM_LNK_ADDR) && (cnt_r == `SCM_ADDR_LAST);
  wire data_edge = (phase_r == SCM_LNK_DATA) && (cnt_r == `SCM_FRAME_LAST);
  wire grst_cmd = addr_edge && (addr_in == `SCM_ADDR_GEN_RESET);
  wire rd_sel = (addr_r == `SCM_ADDR_TONE_STAT);
  wire [3:0] rd_idx = 4'(`SCM_RD_TOP - cnt_r);

  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      SCM_LNK_ADDR:
        if (addr_edge)
          phase_nxt = (addr_in == `SCM_ADDR_GEN_RESET) ? SCM_LNK_DONE : SCM_LNK_DATA;
      SCM_LNK_DATA:
        if (data_edge)
          phase_nxt = SCM_LNK_DONE;
      SCM_LNK_DONE:
        phase_nxt = SCM_LNK_DONE;
      default:
        phase_nxt = SCM_LNK_DONE;
    endcase
  end

  always_ff @(posedge link_sclk or posedge lnk_rst)
  begin
    if (lnk_rst)
    begin
      cnt_r <= 5'd0;
      shift_r <= 23'h00_0000;
      addr_r <= 8'h00;
      phase_r <= SCM_LNK_ADDR;
      rd_sh_r <= 16'h0000;
    end
    else
    begin
      phase_r <= phase_nxt;
      shift_r <= {shift_r[21:0], link_cmd_data};
      if (phase_r != SCM_LNK_DONE)
        cnt_r <= cnt_r + 5'd1;
      if (addr_edge)
        addr_r <= addr_in;
      if (addr_edge)
        rd_sh_r <= shadow_r;
    end
  end

  // Write hand-off: hold word then toggle
  always_ff @(posedge link_sclk or posedge reset)
  begin
    if (reset)
    begin
      hold_addr_r <= 8'h00;
      hold_data_r <= 16'h0000;
      wr_tog_r <= 1'b0;
    end
    else if (grst_cmd)
    begin
      hold_addr_r <= addr_in;
      wr_tog_r <= ~wr_tog_r;
    end
    else if (data_edge && !rd_sel)
    begin
      hold_addr_r <= addr_r;
      hold_data_r <= data_in;
      wr_tog_r <= ~wr_tog_r;
    end
  end

  // Reply driven on falling edge, MSB first
  always_ff @(negedge link_sclk or posedge lnk_rst)
  begin
    if (lnk_rst)
    begin
      reply_r <= 1'b0;
      reply_oe_r <= 1'b0;
    end
    else
    begin
      reply_oe_r <= (phase_r == SCM_LNK_DATA) && rd_sel;
      reply_r <= (phase_r == SCM_LNK_DATA) && rd_sel && rd_sh_r[rd_idx];
    end
  end

  assign link_reply_data = reply_r;
  assign link_reply_oe = reply_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock
  logic tog_lvl;
  logic cs_idle;
  logic tog_prev_r;

  scm_sync #(.RST_VAL(1'b0)) u_tog_sync (
    .clk(sys_clk),
    .reset(reset),
    .async_in(wr_tog_r),
    .level(tog_lvl)
  );

  scm_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk(sys_clk),
    .reset(reset),
    .async_in(link_cs_n),
    .level(cs_idle)
  );

  wire wr_ev = tog_lvl ^ tog_prev_r;
  wire wr_grst = wr_ev && (hold_addr_r == `SCM_ADDR_GEN_RESET);
  wire wr_cfg = wr_ev && (hold_addr_r == `SCM_ADDR_MODEM_CFG);
  wire wr_prog = wr_ev && (hold_addr_r == `SCM_ADDR_PROG);
  wire wr_tx = wr_ev && (hold_addr_r == `SCM_ADDR_TX_PAIR);
  wire wr_aud = wr_ev && (hold_addr_r == `SCM_ADDR_TONE_SEL);
  wire [3:0] aud_sel = hold_data_r[`SCM_AUD_SEL_HI:`SCM_AUD_SEL_LO];
  wire [11:0] aud_val = hold_data_r[`SCM_AUD_VAL_HI:0];
  wire aud_ok = wr_aud && sel_known(aud_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Modem configuration and program word
  scm_cfg_t cfg_r;
  scm_cfg_t cfg_nxt;
  logic [15:0] prog_r;
  logic prog_stb_r;
  wire is_tx = (mode_ctl.op_mode == SCM_OP_TX);
  wire is_rx = (mode_ctl.op_mode == SCM_OP_RX);

  assign cfg_nxt = '{
    frame_pattern_c_detect: hold_data_r[`SCM_CFG_PAT_C],
    frame_pattern_d_detect: hold_data_r[`SCM_CFG_PAT_D],
    frame_pattern_t_detect: hold_data_r[`SCM_CFG_PAT_T],
    weather_data_bypass: hold_data_r[`SCM_CFG_BYPASS],
    selcall_modem_select: hold_data_r[`SCM_CFG_SELCALL],
    raw_mode: hold_data_r[`SCM_CFG_RAW],
    last_block: hold_data_r[`SCM_CFG_LAST],
    user_bit: hold_data_r[`SCM_CFG_USER]
  };

  wire any_pattern = cfg_r.frame_pattern_c_detect | cfg_r.frame_pattern_d_detect | cfg_r.frame_pattern_t_detect;
  wire run_nxt = cfg_r.selcall_modem_select & mode_ctl.modem_en;
  wire raw_rx_nxt = run_nxt & is_rx & cfg_r.raw_mode & any_pattern;
  wire stop_nxt = run_nxt & is_tx & ~cfg_r.raw_mode & cfg_r.last_block;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_r <= scm_cfg_t'(8'h00);
      prog_r <= 16'h0000;
      prog_stb_r <= 1'b0;
      tog_prev_r <= 1'b0;
    end
    else
    begin
      tog_prev_r <= tog_lvl;
      prog_stb_r <= wr_prog;
      if (wr_grst)
        cfg_r <= scm_cfg_t'(8'h00);
      else if (wr_cfg)
        cfg_r <= cfg_nxt;
      if (wr_prog)
        prog_r <= hold_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit character pair
  logic [15:0] pend_r;
  logic pend_vld_r;
  logic [15:0] work_r;
  logic ready_r;
  logic run_r;
  logic raw_rx_r;
  logic stop_r;
  logic [1:0] skip_r;
  wire [15:0] work_nxt = pend_vld_r ? pend_r : work_r;
  wire [1:0] skip_nxt = {work_r[`SCM_TX_FLAG0], work_r[`SCM_TX_FLAG1]} & {2{~cfg_r.raw_mode}};

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pend_r <= 16'h0000;
      pend_vld_r <= 1'b0;
      work_r <= 16'h0000;
      ready_r <= 1'b0;
      run_r <= 1'b0;
      raw_rx_r <= 1'b0;
      stop_r <= 1'b0;
      skip_r <= 2'b00;
    end
    else
    begin
      if (wr_tx)
        pend_r <= hold_data_r;
      pend_vld_r <= wr_tx | (pend_vld_r & ~tx_word_take);
      if (tx_word_take)
        work_r <= work_nxt;
      ready_r <= tx_word_take & is_tx;
      run_r <= run_nxt;
      raw_rx_r <= raw_rx_nxt;
      stop_r <= stop_nxt;
      skip_r <= skip_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tone status
  logic ident_r;
  scm_tone_det_t det_prev_r;
  logic [15:0] stat_r;
  logic event_r;
  wire det_change = (tone_det != det_prev_r);
  wire [15:0] det_word = {1'b0, tone_det.index, tone_det.tone_valid, 10'h000};
  wire [15:0] stat_nxt = is_tx ? 16'h0000 : (ident_r ? IDENT_CODE : det_word);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ident_r <= 1'b1;
      det_prev_r <= scm_tone_det_t'(5'h00);
      stat_r <= 16'h0000;
      event_r <= 1'b0;
      shadow_r <= 16'h0000;
    end
    else
    begin
      det_prev_r <= tone_det;
      ident_r <= wr_grst | (ident_r & ~det_change);
      stat_r <= stat_nxt;
      event_r <= det_change;
      if (cs_idle)
        shadow_r <= stat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Audio tone word
  scm_audio_t aud_r;
  logic tone_on_r;
  logic bias_r;
  localparam scm_audio_t AUD_RST = '{
    freq: `SCM_FREQ_RST,
    tone_level: `SCM_LEVEL_RST,
    rx_voice: `SCM_LEVEL_RST,
    out1_gain: `SCM_LEVEL_RST,
    out2_gain: `SCM_LEVEL_RST,
    tx_mult: `SCM_MULT_RST,
    fine_atten: `SCM_FINE_RST
  };

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      aud_r <= AUD_RST;
    else if (wr_grst)
      aud_r <= AUD_RST;
    else if (aud_ok)
    begin
      case (aud_sel)
        SCM_SEL_FREQ: aud_r.freq <= aud_val;
        SCM_SEL_TONE_LVL: aud_r.tone_level <= aud_val;
        SCM_SEL_RX_VOICE: aud_r.rx_voice <= aud_val;
        SCM_SEL_OUT1: aud_r.out1_gain <= aud_val;
        SCM_SEL_OUT2: aud_r.out2_gain <= aud_val;
        SCM_SEL_TX_MULT: aud_r.tx_mult <= aud_val[2:0];
        SCM_SEL_FINE: aud_r.fine_atten <= aud_val[7:0];
        default: aud_r <= aud_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tone_on_r <= 1'b0;
      bias_r <= 1'b0;
    end
    else
    begin
      tone_on_r <= mode_ctl.tone_gen_en && (aud_r.freq != 12'h000);
      bias_r <= mode_ctl.tone_gen_en && (aud_r.freq == 12'h000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign modem_cfg = cfg_r;
  assign modem_run = run_r;
  assign rx_raw_search = raw_rx_r;
  assign tx_word = work_r;
  assign tx_skip = skip_r;
  assign data_ready = ready_r;
  assign stop_permit = stop_r;
  assign prog_word = prog_r;
  assign prog_strobe = prog_stb_r;
  assign tone_status = stat_r;
  assign tone_event = event_r;
  assign audio_cfg = aud_r;
  assign tone_on = tone_on_r;
  assign bias_only = bias_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  pattern_enables_a: assert property (wr_cfg |=> cfg_r.frame_pattern_c_detect == $past(hold_data_r[15])
    && cfg_r.frame_pattern_t_detect == $past(hold_data_r[13])) else $error("pattern enable not stored");
  bypass_bit_a: assert property (wr_cfg |=> cfg_r.weather_data_bypass == $past(hold_data_r[12]))
    else $error("bypass bit not stored");
  modem_run_a: assert property (run_r |-> $past(cfg_r.selcall_modem_select && mode_ctl.modem_en))
    else $error("modem runs without select and enable");
  stop_permit_a: assert property (stop_r |-> $past(is_tx && !cfg_r.raw_mode && cfg_r.last_block))
    else $error("stop permitted outside formatted transmit");
  repeat_pair_a: assert property (tx_word_take && !pend_vld_r |=> $stable(work_r))
    else $error("pair not repeated");
  finish_word_a: assert property (!tx_word_take |=> $stable(work_r))
    else $error("word changed mid transfer");
  char_skip_a: assert property (cfg_r.raw_mode |=> skip_r == 2'b00)
    else $error("raw mode skipped a character");
  ident_code_a: assert property (wr_grst && !det_change && !is_tx ##1 !det_change && !is_tx |=>
    stat_r == IDENT_CODE) else $error("identification code not shown");
  tx_zero_a: assert property (is_tx |=> stat_r == 16'h0000)
    else $error("tone status nonzero in transmit");
  tone_event_a: assert property (det_change |=> event_r ##1 (event_r == $past(det_change)))
    else $error("tone change missed");
  reserved_sel_a: assert property (wr_aud && !sel_known(aud_sel) && !wr_grst |=> $stable(aud_r))
    else $error("reserved select altered settings");
  freq_apply_a: assert property (aud_ok && aud_sel == 4'h0 |=> aud_r.freq == $past(aud_val)
    ##1 tone_on_r == $past(mode_ctl.tone_gen_en && aud_r.freq != 12'h000)) else $error("frequency not applied");
  data_ready_a: assert property (tx_word_take && is_tx |=> data_ready)
    else $error("data ready not raised");

  retransmit_c: cover property (tx_word_take && !pend_vld_r && is_tx);
  tone_write_c: cover property (aud_ok && aud_sel == 4'h0 ##[1:50] tone_on_r);
  last_block_c: cover property (stop_r);
  tone_change_c: cover property (event_r && !ident_r);

endmodule : scm_regs

/* File: rtl/scm_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module scm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  wire agree = (s2_r == s3_r);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_r <= RST_VAL;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
        level_r <= s3_r;
    end
  end

  assign level = level_r;

endmodule : scm_sync

/* File: test/scm_host.sv */
// Host controller model driving the serial control bus
`timescale 1ns/1ps
module scm_host (
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_cmd_data,
  input wire logic link_reply_data,
  input wire logic link_reply_oe
);
  logic [15:0] rd_word;
  logic rd_oe;

  initial
  begin
    link_sclk = 1'b1;
    link_cs_n = 1'b1;
    link_cmd_data = 1'b1;
    rd_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first; clock idles high, reply taken on rising edges
  task automatic frame(input logic [23:0] bits, input int n);
    int i;
    begin
      #3;
      link_cs_n = 1'b0;
      rd_oe = 1'b0;
      #16;
      for (i = 0; i < n; i++)
      begin
        link_sclk = 1'b0;
        link_cmd_data = bits[23 - i];
        #16;
        link_sclk = 1'b1;
        if (i >= 8)
        begin
          rd_word = {rd_word[14:0], link_reply_data};
          rd_oe = rd_oe | link_reply_oe;
        end
        #16;
      end
      link_cs_n = 1'b1;
      // Released line shows the inverse of the last bit
      link_cmd_data = ~link_cmd_data;
      #240;
    end
  endtask : frame
endmodule : scm_host

/* File: test/selcall_modem_tone_registers_bench.sv */
// Testbench for the selcall modem register bank
`timescale 1ns/1ps
`include "scm_params.svh"
`define CHK(got, exp, msg) \
  begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module selcall_modem_tone_registers_bench;
  import scm_pkg::*;
  localparam logic [15:0] IDENT = 16'h3c96; // Arbitrary value
  logic sys_clk, reset, link_sclk, link_cs_n, link_cmd_data, link_reply_data, link_reply_oe;
  scm_mode_t mode_ctl;
  scm_tone_det_t tone_det;
  logic tx_word_take;
  scm_cfg_t modem_cfg;
  logic modem_run, rx_raw_search, data_ready, stop_permit, prog_strobe, tone_event, tone_on, bias_only;
  logic [15:0] tx_word, prog_word, tone_status;
  logic [1:0] tx_skip;
  scm_audio_t audio_cfg;
  int fail_count = 0;
  int num_checks = 0;
  int dr_cnt = 0;
  int te_cnt = 0;
  int ps_cnt = 0;
  int n;
  logic [15:0] aw [10] = '{16'h0123, 16'h2234, 16'h4345, 16'h6456, 16'h8567, 16'ha005, 16'hc0a3,
                          16'hb777, 16'hd777, 16'hf777};

  scm_regs #(.IDENT_CODE(IDENT)) scm_regs_inst (.sys_clk(sys_clk), .reset(reset), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_cmd_data(link_cmd_data), .link_reply_data(link_reply_data),
    .link_reply_oe(link_reply_oe), .mode_ctl(mode_ctl), .tone_det(tone_det), .tx_word_take(tx_word_take),
    .modem_cfg(modem_cfg), .modem_run(modem_run), .rx_raw_search(rx_raw_search), .tx_word(tx_word),
    .tx_skip(tx_skip), .data_ready(data_ready), .stop_permit(stop_permit), .prog_word(prog_word),
    .prog_strobe(prog_strobe), .tone_status(tone_status), .tone_event(tone_event), .audio_cfg(audio_cfg),
    .tone_on(tone_on), .bias_only(bias_only));

  scm_host scm_host_inst (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_cmd_data(link_cmd_data),
    .link_reply_data(link_reply_data), .link_reply_oe(link_reply_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and pulse counters
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (data_ready === 1'b1) dr_cnt <= dr_cnt + 1;
    if (tone_event === 1'b1) te_cnt <= te_cnt + 1;
    if (prog_strobe === 1'b1) ps_cnt <= ps_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    scm_host_inst.frame({a, d}, 24);
    cyc(4);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    scm_host_inst.frame({a, 16'h0000}, 24);
  endtask : rd

  task automatic take();
    @(posedge sys_clk);
    tx_word_take <= 1'b1;
    @(posedge sys_clk);
    tx_word_take <= 1'b0;
    cyc(3);
  endtask : take

  task automatic setm(input scm_opmode_t op, input logic en, input logic tg);
    @(posedge sys_clk);
    mode_ctl <= {op, en, tg};
    cyc(3);
  endtask : setm

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  initial
  begin
    #500000;
    fail_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    reset = 1'b1;
    mode_ctl = '0;
    tone_det = '0;
    tx_word_take = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(4);
    `CHK(modem_cfg, 8'h00, "cfg reset")
    `CHK(audio_cfg.tone_level, 12'hfff, "level reset")
    `CHK(tone_status, IDENT, "ident word")
    rd(`SCM_ADDR_TONE_STAT);
    `CHK(scm_host_inst.rd_word, IDENT, "ident read")
    rd(`SCM_ADDR_MODEM_CFG);
    `CHK(scm_host_inst.rd_oe, 1'b0, "write-only reply")
    $display("test reset done");

    wr(`SCM_ADDR_MODEM_CFG, 16'he404);
    `CHK(modem_cfg, 8'he5, "pattern and user bits")
    setm(SCM_OP_RX, 1'b1, 1'b0);
    `CHK(modem_run, 1'b0, "run without select")
    wr(`SCM_ADDR_MODEM_CFG, 16'hec04);
    `CHK(modem_run, 1'b1, "run")
    `CHK(rx_raw_search, 1'b1, "raw search")
    setm(SCM_OP_RX, 1'b0, 1'b0);
    `CHK(modem_run, 1'b0, "stop")
    `CHK(rx_raw_search, 1'b0, "search off")
    wr(`SCM_ADDR_MODEM_CFG, 16'h1000);
    `CHK(modem_cfg, 8'h10, "bypass bit")
    $display("test config done");

    wr(`SCM_ADDR_MODEM_CFG, 16'h0a00);
    setm(SCM_OP_TX, 1'b1, 1'b0);
    `CHK(stop_permit, 1'b1, "stop permit")
    `CHK(tone_status, 16'h0000, "status in tx")
    rd(`SCM_ADDR_TONE_STAT);
    `CHK(scm_host_inst.rd_word, 16'h0000, "status read in tx")
    n = dr_cnt;
    wr(`SCM_ADDR_TX_PAIR, 16'h8142);
    `CHK(tx_word, 16'h0000, "no switch before take")
    take();
    `CHK(tx_word, 16'h8142, "new pair")
    `CHK(tx_skip, 2'b10, "flagged char skipped")
    `CHK(dr_cnt, n + 1, "data ready")
    take();
    `CHK(tx_word, 16'h8142, "repeat pair")
    `CHK(dr_cnt, n + 2, "data ready again")
    wr(`SCM_ADDR_MODEM_CFG, 16'h0e00);
    `CHK(stop_permit, 1'b0, "no stop in raw")
    wr(`SCM_ADDR_TX_PAIR, 16'h8180);
    take();
    `CHK(tx_word, 16'h8180, "raw word")
    `CHK(tx_skip, 2'b00, "no skip in raw")
    $display("test transmit done");

    setm(SCM_OP_RX, 1'b0, 1'b0);
    n = te_cnt;
    @(posedge sys_clk);
    tone_det <= {4'h5, 1'b1};
    cyc(4);
    `CHK(tone_status, 16'h2c00, "tone index")
    `CHK(te_cnt, n + 1, "tone event")
    rd(`SCM_ADDR_TONE_STAT);
    `CHK(scm_host_inst.rd_word, 16'h2c00, "tone read")
    `CHK(scm_host_inst.rd_oe, 1'b1, "reply enabled")
    @(posedge sys_clk);
    tone_det <= {4'h5, 1'b0};
    cyc(4);
    `CHK(tone_status, 16'h2800, "valid cleared")
    `CHK(te_cnt, n + 2, "valid change event")
    $display("test tone status done");

    for (int i = 0; i < 10; i++)
      wr(`SCM_ADDR_TONE_SEL, aw[i]);
    `CHK(audio_cfg, {12'h123, 12'h234, 12'h345, 12'h456, 12'h567, 3'h5, 8'ha3}, "audio fields")
    setm(SCM_OP_RX, 1'b0, 1'b1);
    `CHK(tone_on, 1'b1, "tone plays")
    wr(`SCM_ADDR_TONE_SEL, 16'h0000);
    `CHK(bias_only, 1'b1, "bias only")
    `CHK(tone_on, 1'b0, "tone off")
    wr(`SCM_ADDR_TONE_SEL, 16'h0bb8);
    `CHK(audio_cfg.freq, 12'hbb8, "freq while playing")
    `CHK(tone_on, 1'b1, "tone again")
    $display("test audio done");

    n = ps_cnt;
    wr(`SCM_ADDR_PROG, 16'h1234);
    `CHK(prog_word, 16'h1234, "program word")
    `CHK(ps_cnt, n + 1, "program strobe")
    wr(`SCM_ADDR_MODEM_CFG, 16'hec04);
    scm_host_inst.frame({`SCM_ADDR_GEN_RESET, 16'h0000}, 8);
    cyc(4);
    `CHK(modem_cfg, 8'h00, "cfg cleared")
    `CHK(audio_cfg.rx_voice, 12'hfff, "levels restored")
    `CHK(tone_status, IDENT, "ident again")
    $display("test general reset done");
    results();
  end
endmodule : selcall_modem_tone_registers_bench
